// file: cse_fabric_model.sv
// Interconnect model that drives the logic block input pins
`timescale 1ns/1ns
module cse_fabric_model
   import cse_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Requested pin levels and pad inversion
   input wire cse_pins_t i_req,
   input wire logic i_gz_invert,
   // Pins toward the logic block
   output cse_pins_t o_pins
);
   ////////////////////////////////////////////////////////////////////////////
   // Launch pin levels after an edge; global zero comes from a pad, maybe inverted
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pins <= '0;
      end
      else
      begin
         o_pins <= i_req;
         o_pins.global_zero_net <= i_req.global_zero_net ^ i_gz_invert;
      end
   end
endmodule // cse_fabric_model

// file: cse_logic_block.sv
// Four logic cells with configurable storage elements behind an APB slave
//
// Contract
// - Each cell has a 4-input lookup, five inputs, three outputs, storage, chaining.
// - Each storage element is a flip-flop or a transparent latch, per cell.
// - Power-up, reconfiguration or global zero net force every element to 0.
// - High zero input clears every element without clr_disable set at once, ignoring clock and enable.
// - Flip-flop takes data on selected active edge when enabled; else holds.
// - Latch follows data at inactive clock level, holds at active level.
// - Enable is active high; low enable holds every element with connected enable in both modes.
// - An element with unconnected enable is permanently enabled.
// - Unconnected zero input reads low, unconnected enable reads high.
// - One shared clock and one enable; enable and zero not invertible.
// - Each element selects rising or falling edge of the shared clock.
// - Zero input can be disabled per element.
// - Element data comes from the lookup result or the bypass input.
// - Four bypass paths route bypass input straight to bypass output.
// - Each cell always presents its lookup result as combinational output.
// - Chain selectors cascade cell to cell for wide AND/OR decode.
`timescale 1ns/1ns
module cse_logic_block
   import cse_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // Interconnect inputs
   input wire cse_pins_t i_pins,
   // Cell outputs
   output logic [CSE_N_CELLS-1:0] o_storage_q,
   output logic [CSE_N_CELLS-1:0] o_comb_x,
   output logic [CSE_N_CELLS-1:0] o_bypass_out,
   output logic o_chain_out
);

   cse_pins_t pins;
   cse_cfg_t cfg_q;
   logic [CSE_LUT_BITS-1:0] lut_q [CSE_N_CELLS];
   logic edge_prev_q;
   logic rise;
   logic fall;
   logic force_zero;
   logic zero_req;
   logic en_raw;
   logic [CSE_N_CELLS-1:0] lut_out;
   logic [CSE_N_CELLS-1:0] data_sel;
   logic [CSE_N_CELLS-1:0] act_edge;
   logic [CSE_N_CELLS-1:0] lvl_act;
   logic [CSE_N_CELLS-1:0] en_eff;
   logic [CSE_N_CELLS-1:0] clr_eff;
   logic [CSE_N_CELLS:0] chain;
   logic [CSE_N_CELLS-1:0] storage_q;
   logic acc;
   logic addr_ok;
   logic wr_go;
   logic [31:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation
   cse_sync #(.W(CSE_PINS_W)) u_pin_sync (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_d(i_pins),
      .o_q(pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, error on unmapped or unaligned address
   assign acc = i_psel & i_penable & ~o_pready;
   assign wr_go = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
   assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr <= CSE_STAT_OFS);

   // Read mux
   always_comb
   begin
      rd_word = CSE_ZERO_WORD;
      case (i_paddr)
         CSE_CFG_OFS: rd_word = cfg_q;
         CSE_LUT0_OFS: rd_word = {16'h0000, lut_q[0]};
         CSE_LUT1_OFS: rd_word = {16'h0000, lut_q[1]};
         CSE_LUT2_OFS: rd_word = {16'h0000, lut_q[2]};
         CSE_LUT3_OFS: rd_word = {16'h0000, lut_q[3]};
         CSE_STAT_OFS: rd_word = {19'h00000, o_chain_out, o_bypass_out, o_comb_x, o_storage_q};
         default: rd_word = CSE_ZERO_WORD;
      endcase
   end

   // Handshake outputs
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= CSE_ZERO_WORD;
      end
      else
      begin
         o_pready <= acc;
         o_pslverr <= acc & ~addr_ok;
         if (acc)
            o_prdata <= (addr_ok && !i_pwrite) ? rd_word : CSE_ZERO_WORD;
      end
   end

   // Error only ever comes with ready
   a_err_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_pslverr |-> o_pready)
      else $error("slave error without ready");

   // Read data holds between accesses
   a_rdata_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      !acc |=> $stable(o_prdata))
      else $error("read data changed outside an access");

   // Configuration register
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cfg_q <= CSE_CFG_RST;
      else if (wr_go && i_paddr == CSE_CFG_OFS)
         cfg_q <= i_pwdata & CSE_CFG_WMASK;
   end

   // Lookup truth tables
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         for (int k = 0; k < CSE_N_CELLS; k++)
            lut_q[k] <= CSE_LUT_RST;
      end
      else if (wr_go)
      begin
         for (int k = 0; k < CSE_N_CELLS; k++)
            if (i_paddr == CSE_LUT0_OFS + 8'(4 * k))
               lut_q[k] <= i_pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared clock edge detection on the synchronised cell clock
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         edge_prev_q <= 1'b0;
      else
         edge_prev_q <= pins.cell_edge_input;
   end

   assign rise = pins.cell_edge_input & ~edge_prev_q;
   assign fall = ~pins.cell_edge_input & edge_prev_q;
   // Global zero and reconfiguration override all else
   assign force_zero = pins.global_zero_net | cfg_q.reconfig;
   // Zero input reads low when unconnected, never inverted
   assign zero_req = cfg_q.clr_used & pins.async_zero_input;
   assign en_raw = pins.clk_en;
   assign chain[0] = pins.chain_in;

   ////////////////////////////////////////////////////////////////////////////
   // Per-cell logic
   for (genvar i = 0; i < CSE_N_CELLS; i++)
   begin : g_cell
      // Lookup of four inputs
      assign lut_out[i] = lut_q[i][pins.lut_in[CSE_LUT_INS*i +: CSE_LUT_INS]];
      // Data source select
      assign data_sel[i] = cfg_q.dsel_bypass[i] ? pins.bypass_input[i] : lut_out[i];
      // Edge and level polarity per element
      assign act_edge[i] = cfg_q.edge_fall[i] ? fall : rise;
      assign lvl_act[i] = cfg_q.edge_fall[i] ? ~pins.cell_edge_input : pins.cell_edge_input;
      // Unconnected enable is active
      assign en_eff[i] = ~cfg_q.en_used[i] | en_raw;
      // Per-element zero disable
      assign clr_eff[i] = zero_req & ~cfg_q.clr_disable[i];
      // Cascade selector
      assign chain[i+1] = lut_out[i] ? chain[i] : cfg_q.chain_const[i];

      // Storage element
      always_ff @(posedge i_core_clk or negedge i_rst_b)
      begin
         if (!i_rst_b)
            storage_q[i] <= 1'b0;
         else if (force_zero || clr_eff[i])
            storage_q[i] <= 1'b0;
         else if (en_eff[i])
         begin
            if (cfg_q.latch_mode[i])
            begin
               if (!lvl_act[i])
                  storage_q[i] <= data_sel[i];
            end
            else if (act_edge[i])
               storage_q[i] <= data_sel[i];
         end
      end

      // Flip-flop captures on active edge
      a_ff_capture: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
         (!force_zero && !clr_eff[i] && en_eff[i] && !cfg_q.latch_mode[i] && act_edge[i])
         |=> storage_q[i] == $past(data_sel[i]))
         else $error("flip-flop missed data on active edge");

      // Flip-flop holds without edge
      a_ff_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
         (!force_zero && !clr_eff[i] && !cfg_q.latch_mode[i] && !act_edge[i])
         |=> $stable(storage_q[i]))
         else $error("flip-flop changed without active edge");

      // Latch transparent at inactive level
      a_latch_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
         (!force_zero && !clr_eff[i] && en_eff[i] && cfg_q.latch_mode[i] && !lvl_act[i])
         |=> storage_q[i] == $past(data_sel[i]))
         else $error("latch did not follow data");

      // Latch opaque at active level
      a_latch_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
         (!force_zero && !clr_eff[i] && cfg_q.latch_mode[i] && lvl_act[i])
         |=> $stable(storage_q[i]))
         else $error("latch changed at active level");

      // Low enable holds in both modes
      a_enable_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
         (!force_zero && !clr_eff[i] && cfg_q.en_used[i] && !en_raw)
         |=> $stable(storage_q[i]))
         else $error("element changed while disabled");

      // Exempt element still captures while zero input is high
      a_clr_masked: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
         (zero_req && cfg_q.clr_disable[i] && !force_zero && en_eff[i]
          && !cfg_q.latch_mode[i] && act_edge[i])
         |=> storage_q[i] == $past(data_sel[i]))
         else $error("masked element was cleared");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered cell outputs
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_storage_q <= '0;
         o_comb_x <= '0;
         o_bypass_out <= '0;
         o_chain_out <= 1'b0;
      end
      else
      begin
         o_storage_q <= storage_q;
         o_comb_x <= lut_out;
         o_bypass_out <= pins.bypass_input;
         o_chain_out <= chain[CSE_N_CELLS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks across cells
   a_global_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      force_zero |=> storage_q == '0 ##1 o_storage_q == '0)
      else $error("global zero did not clear all elements");

   a_zero_all: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      zero_req |=> (storage_q & ~$past(cfg_q.clr_disable)) == '0)
      else $error("zero input did not clear enabled elements");

   a_bypass_path: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      ##1 o_bypass_out == $past(pins.bypass_input))
      else $error("bypass output not equal to bypass input");

   a_comb_out: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      ##1 o_comb_x == $past(lut_out))
      else $error("combinational output not lookup result");

   a_chain_and: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (cfg_q.chain_const == 4'h0 && lut_out != 4'hF) |=> !o_chain_out)
      else $error("AND cascade passed with a lookup low");

   a_chain_or: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (cfg_q.chain_const == 4'hF && lut_out != 4'hF) |=> o_chain_out)
      else $error("OR cascade missed a lookup low");

   a_chain_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      (lut_out == 4'hF) |=> o_chain_out == $past(pins.chain_in))
      else $error("cascade did not pass the chain input");

   a_reconfig_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      cfg_q.reconfig |=> storage_q == '0)
      else $error("reconfiguration did not clear all elements");

   // Output register mirrors the elements
   a_store_copy: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      ##1 o_storage_q == $past(storage_q))
      else $error("storage output not equal to element");

   a_pready_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      o_pready |=> !o_pready)
      else $error("pready held more than one cycle");

endmodule // cse_logic_block

// file: cse_pkg.sv
// Shared constants, register map and carrier types for the logic block storage
package cse_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Geometry
   localparam int CSE_N_CELLS = 4;
   localparam int CSE_LUT_INS = 4;
   localparam int CSE_LUT_BITS = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [7:0] CSE_CFG_OFS = 8'h00;
   localparam logic [7:0] CSE_LUT0_OFS = 8'h04;
   localparam logic [7:0] CSE_LUT1_OFS = 8'h08;
   localparam logic [7:0] CSE_LUT2_OFS = 8'h0C;
   localparam logic [7:0] CSE_LUT3_OFS = 8'h10;
   localparam logic [7:0] CSE_STAT_OFS = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and write masks
   localparam logic [31:0] CSE_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CSE_CFG_WMASK = 32'h81FF_FFFF;
   localparam logic [15:0] CSE_LUT_RST = 16'h0000;
   localparam logic [31:0] CSE_ZERO_WORD = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Synchroniser depth for pins from the interconnect
   localparam int CSE_SYNC_STAGES = 3;

   // Configuration word, one bit per cell in each four-bit field
   typedef struct packed {
      logic reconfig;           // 31: hold every element cleared
      logic [5:0] rsvd;         // 30:25
      logic [3:0] chain_const;  // 24:21 selector value when lookup is 0
      logic clr_used;           // 20: zero input connected
      logic [3:0] en_used;      // 19:16 enable connected per cell
      logic [3:0] dsel_bypass;  // 15:12 data from bypass input
      logic [3:0] clr_disable;  // 11:8 element ignores zero input
      logic [3:0] edge_fall;    // 7:4 falling edge / low level active
      logic [3:0] latch_mode;   // 3:0 latch instead of flip-flop
   } cse_cfg_t;

   // Inputs from the programmable interconnect
   typedef struct packed {
      logic global_zero_net;
      logic cell_edge_input;
      logic clk_en;
      logic async_zero_input;
      logic chain_in;
      logic [3:0] bypass_input;
      logic [15:0] lut_in;
   } cse_pins_t;

   localparam int CSE_PINS_W = $bits(cse_pins_t);

endpackage

// file: cse_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module cse_sync
   import cse_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   // Data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // Stage chain; first stage feeds only the second
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Bit changes only when stages two and three agree
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_q <= '0;
      else
         o_q <= (s2_q & s3_q) | (o_q & (s2_q ^ s3_q));
   end

endmodule // cse_sync

// file: tb.sv
// Self-checking bench for the logic block storage elements
`timescale 1ns/1ns
module tb;
   import cse_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, chain_o, gz_inv = 1'b0;
   logic [31:0] prdata, rd_v;
   logic err_v;
   logic [3:0] st_q, comb_x, byp_o;
   cse_pins_t req = '0;
   cse_pins_t pins;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Design, far-side model and clock
   cse_logic_block i_dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_pins(pins),
      .o_storage_q(st_q), .o_comb_x(comb_x), .o_bypass_out(byp_o), .o_chain_out(chain_o));
   cse_fabric_model i_fab (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_req(req),
      .i_gz_invert(gz_inv), .o_pins(pins));
   always #25 core_clk = ~core_clk;

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic close_out;
   begin
      if (error_cnt == 0 && checked > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   end
   endtask

   // Value compare, storage compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task automatic chq(input logic [3:0] e);
   begin
      chk(32'(st_q), 32'(e));
   end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
   begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task automatic rd(input logic [7:0] a);
   begin
      apb(1'b0, a, 32'h0000_0000);
   end
   endtask
   task automatic cfg(input logic [31:0] v);
   begin
      apb(1'b1, CSE_CFG_OFS, v);
   end
   endtask

   // Pin timing: synchroniser plus output register, with margin
   task automatic settle;
   begin
      repeat (10) @(posedge core_clk);
   end
   endtask
   task automatic edge_to(input logic v);
   begin
      @(posedge core_clk);
      req.cell_edge_input <= v;
      settle();
   end
   endtask
   task automatic edge_cycle;
   begin
      edge_to(1'b0);
      edge_to(1'b1);
   end
   endtask
   task automatic set_byp(input logic [3:0] v);
   begin
      @(posedge core_clk);
      req.bypass_input <= v;
      settle();
   end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      chq(4'h0);
      rd(CSE_CFG_OFS);
      chk(rd_v, CSE_CFG_RST);
      rd(8'h18);
      chk(32'(err_v), 32'h0000_0001);
      chk(rd_v, CSE_ZERO_WORD);
      rd(8'h06);
      chk(32'(err_v), 32'h0000_0001);
      cfg(32'hFFFF_FFFF);
      rd(CSE_CFG_OFS);
      chk(rd_v, CSE_CFG_WMASK);
      cfg(32'h0000_0000);
      // Four-input AND tables, cascade and feed-through
      for (int i = 0; i < 4; i++) apb(1'b1, CSE_LUT0_OFS + 8'(4 * i), 32'h0000_8000);
      rd(CSE_LUT2_OFS);
      chk(rd_v, 32'h0000_8000);
      @(posedge core_clk);
      req.lut_in <= 16'hFFFF;
      req.chain_in <= 1'b1;
      set_byp(4'hA);
      chk(32'(comb_x), 32'h0000_000F);
      chk(32'(chain_o), 32'h0000_0001);
      chk(32'(byp_o), 32'h0000_000A);
      @(posedge core_clk);
      req.lut_in <= 16'hFFFE;
      settle();
      chk(32'(comb_x), 32'h0000_000E);
      chk(32'(chain_o), 32'h0000_0000);
      cfg(32'h01E0_0000);
      settle();
      chk(32'(chain_o), 32'h0000_0001);
      cfg(32'h0000_0000);
      edge_cycle();
      chq(4'hE);
      rd(CSE_STAT_OFS);
      chk(rd_v, 32'h0000_0AEE);
      // Flip-flop from bypass, hold, per-cell polarity
      cfg(32'h0000_F000);
      set_byp(4'h5);
      edge_cycle();
      chq(4'h5);
      set_byp(4'hA);
      chq(4'h5);
      cfg(32'h0000_F030);
      edge_to(1'b0);
      chq(4'h6);
      edge_to(1'b1);
      chq(4'hA);
      // Enable low holds; unconnected enable always on
      cfg(32'h000F_F000);
      set_byp(4'h5);
      edge_cycle();
      chq(4'hA);
      cfg(32'h0003_F000);
      edge_cycle();
      chq(4'h6);
      @(posedge core_clk);
      req.clk_en <= 1'b1;
      edge_cycle();
      chq(4'h5);
      // Zero input with cell 0 exempt, then left unconnected
      cfg(32'h0010_F100);
      @(posedge core_clk);
      req.bypass_input <= 4'hF;
      req.async_zero_input <= 1'b1;
      settle();
      chq(4'h1);
      edge_cycle();
      chq(4'h1);
      cfg(32'h0000_F100);
      edge_cycle();
      chq(4'hF);
      // Latch mode
      cfg(32'h0000_F00F);
      set_byp(4'h0);
      chq(4'hF);
      edge_to(1'b0);
      chq(4'h0);
      set_byp(4'h6);
      chq(4'h6);
      edge_to(1'b1);
      set_byp(4'h3);
      chq(4'h6);
      // Global zero net, pad inversion, reconfiguration
      @(posedge core_clk);
      req.global_zero_net <= 1'b1;
      settle();
      chq(4'h0);
      edge_to(1'b0);
      chq(4'h0);
      @(posedge core_clk);
      req.global_zero_net <= 1'b0;
      settle();
      chq(4'h3);
      @(posedge core_clk);
      gz_inv <= 1'b1;
      settle();
      chq(4'h0);
      @(posedge core_clk);
      gz_inv <= 1'b0;
      settle();
      cfg(32'h8000_F00F);
      settle();
      chq(4'h0);
      cfg(32'h0000_F00F);
      settle();
      chq(4'h3);
      apb(1'b1, CSE_STAT_OFS, 32'hFFFF_FFFF);
      chk(32'(err_v), 32'h0000_0000);
      rd(CSE_STAT_OFS);
      chk(rd_v, 32'h0000_03E3);
      // Reset in mid-run empties every element and the configuration
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      settle();
      chq(4'h0);
      rd(CSE_CFG_OFS);
      chk(rd_v, CSE_CFG_RST);
      close_out();
   end
endmodule // tb
